//--- rtl/cfc_top.sv
`timescale 1ns/1ps
`include "cfc_map.svh"
module cfc_top import cfc_pkg::*; #(
	parameter int HALF_BIT = `CFC_HALF_BIT
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`CFC_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_sck,
	output logic o_fsync,
	output logic o_serial_data_out,
	output logic o_serial_data_out_oe_n,
	input wire logic i_serial_data_in,
	output logic o_irq
);
	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [15:0] framing_q, framing_d;
	logic [15:0] rx_slot_enable_q, rx_slot_enable_d;
	logic [15:0] tx_slot_enable_q, tx_slot_enable_d;
	logic [1:0] ctl_q, ctl_d;
	logic [15:0] tx_data_q, tx_data_d;
	logic [1:0] sts_q, sts_d;
	logic [1:0] mask_q, mask_d;
	logic [1:0] sts_set;
	logic acc, wr, rd, hit, is_buf;
	logic [15:0] buf_rdata;
	logic [31:0] rdata;

	always_comb begin
		acc = i_psel & i_penable;
		wr = acc & i_pwrite;
		rd = acc & ~i_pwrite;
		is_buf = ((i_paddr & `CFC_RX_BUF_SEL) == `CFC_OFS_RX_BUF) && (i_paddr[1:0] == 2'h0);
		hit = 1'b1;
		rdata = 32'h0000_0000;
		unique case (i_paddr)
			`CFC_OFS_FRAMING: rdata[15:0] = framing_q;
			`CFC_OFS_RX_SLOTS: rdata[15:0] = rx_slot_enable_q;
			`CFC_OFS_TX_SLOTS: rdata[15:0] = tx_slot_enable_q;
			`CFC_OFS_CONTROL: rdata[1:0] = ctl_q;
			`CFC_OFS_TX_DATA: rdata[15:0] = tx_data_q;
			`CFC_OFS_STATUS: rdata[1:0] = sts_q;
			`CFC_OFS_MASK: rdata[1:0] = mask_q;
			default: begin
				hit = is_buf;
				rdata[15:0] = is_buf ? buf_rdata : `CFC_RST_16;
			end
		endcase
		framing_d = framing_q;
		rx_slot_enable_d = rx_slot_enable_q;
		tx_slot_enable_d = tx_slot_enable_q;
		ctl_d = ctl_q;
		tx_data_d = tx_data_q;
		mask_d = mask_q;
		if (wr) begin
			unique case (i_paddr)
				`CFC_OFS_FRAMING: framing_d = i_pwdata[15:0] & `CFC_FRAMING_MASK;
				`CFC_OFS_RX_SLOTS: rx_slot_enable_d = i_pwdata[15:0];
				`CFC_OFS_TX_SLOTS: tx_slot_enable_d = i_pwdata[15:0];
				`CFC_OFS_CONTROL: ctl_d = i_pwdata[1:0];
				`CFC_OFS_TX_DATA: tx_data_d = i_pwdata[15:0];
				`CFC_OFS_MASK: mask_d = i_pwdata[1:0];
				default: ;
			endcase
		end
		// Read clears status; a set in the same cycle survives
		sts_d = sts_q;
		if (rd && i_paddr == `CFC_OFS_STATUS) begin
			sts_d = '0;
		end
		sts_d = sts_d | sts_set;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			framing_q <= `CFC_RST_16;
			rx_slot_enable_q <= `CFC_RST_16;
			tx_slot_enable_q <= `CFC_RST_16;
			ctl_q <= `CFC_RST_CTL;
			tx_data_q <= `CFC_RST_16;
			sts_q <= `CFC_RST_STS;
			mask_q <= `CFC_RST_STS;
		end else begin
			framing_q <= framing_d;
			rx_slot_enable_q <= rx_slot_enable_d;
			tx_slot_enable_q <= tx_slot_enable_d;
			ctl_q <= ctl_d;
			tx_data_q <= tx_data_d;
			sts_q <= sts_d;
			mask_q <= mask_d;
		end
	end

	assign o_prdata = rdata;
	assign o_pready = 1'b1;
	assign o_pslverr = acc & ~hit;
	assign o_irq = |(sts_q & mask_q);

	// ----------------------------------------------------------------
	// Serial link framing
	// ----------------------------------------------------------------
	logic rise, fall, start;
	cfc_state_t st_q, st_d;
	logic [3:0] bit_q, bit_d, slot_q, slot_d;
	logic [1:0] wcnt_q, wcnt_d;
	logic [15:0] txsh_q, txsh_d, rxsh_q, rxsh_d;
	logic sdo_q, sdo_d, oen_q, oen_d, fs_q, fs_d;
	cfc_link_cfg_t lcfg_q, lcfg_d, live, ccfg;
	cfc_wr_t push;

	cfc_bitclk #(.HALF(HALF_BIT)) u_bitclk (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.o_sck(o_sck),
		.o_rise(rise),
		.o_fall(fall)
	);

	cfc_mem #(.W(16), .D(4)) u_rxbuf (
		.i_clk(i_clk),
		.i_wr(push),
		.i_raddr(i_paddr[3:2]),
		.o_rdata(buf_rdata)
	);

	always_comb begin
		live.buf_len = framing_q[`CFC_BUF_LEN_MSB:`CFC_BUF_LEN_LSB];
		live.frm = framing_q[`CFC_FRM_MSB:`CFC_FRM_LSB];
		live.word_size = framing_q[`CFC_WORD_SIZE_MSB:`CFC_WORD_SIZE_LSB];
		live.rx_en = rx_slot_enable_q;
		live.tx_en = tx_slot_enable_q;
		live.idle_low = ctl_q[`CFC_CTL_IDLE_LOW];
		st_d = st_q;
		bit_d = bit_q;
		slot_d = slot_q;
		lcfg_d = lcfg_q;
		txsh_d = txsh_q;
		rxsh_d = rxsh_q;
		sdo_d = sdo_q;
		oen_d = oen_q;
		fs_d = fs_q;
		wcnt_d = wcnt_q;
		sts_set = '0;
		push = '0;
		start = 1'b0;
		ccfg = lcfg_q;
		if (fall) begin
			unique case (st_q)
				CFC_ST_IDLE: begin
					if (ctl_q[`CFC_CTL_EN]) begin
						st_d = CFC_ST_RUN;
						bit_d = '0;
						slot_d = '0;
					end
				end
				CFC_ST_RUN: begin
					if (!ctl_q[`CFC_CTL_EN]) begin
						st_d = CFC_ST_IDLE;
					end else if (bit_q == lcfg_q.word_size) begin
						bit_d = '0;
						slot_d = (slot_q == lcfg_q.frm) ? 4'h0 : slot_q + 4'h1;
					end else begin
						bit_d = bit_q + 4'h1;
					end
				end
			endcase
			start = (st_d == CFC_ST_RUN) && (bit_d == '0) && (slot_d == '0);
			if (start) begin
				lcfg_d = live;
				ccfg = live;
				sts_set[`CFC_STS_FRAME] = 1'b1;
			end
			if (st_d == CFC_ST_RUN) begin
				if (bit_d == '0) begin
					txsh_d = tx_data_q << (`CFC_TOP_BIT - ccfg.word_size);
				end else begin
					txsh_d = {txsh_q[14:0], 1'b0};
				end
				fs_d = start;
				if (ccfg.tx_en[slot_d]) begin
					sdo_d = txsh_d[15];
					oen_d = 1'b0;
				end else begin
					sdo_d = 1'b0;
					oen_d = ~ccfg.idle_low;
				end
			end else begin
				sdo_d = 1'b0;
				oen_d = 1'b1;
				fs_d = 1'b0;
			end
		end
		if (rise && st_q == CFC_ST_RUN && lcfg_q.rx_en[slot_q]) begin
			rxsh_d = {rxsh_q[14:0], i_serial_data_in};
			if (bit_q == lcfg_q.word_size) begin
				push.en = 1'b1;
				push.addr = wcnt_q;
				push.data = rxsh_d;
				// A shortened length must not leave the index past the new end
				if (wcnt_q >= lcfg_q.buf_len) begin
					wcnt_d = '0;
					sts_set[`CFC_STS_BUF] = 1'b1;
				end else begin
					wcnt_d = wcnt_q + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= CFC_ST_IDLE;
			bit_q <= '0;
			slot_q <= '0;
			lcfg_q <= '0;
			txsh_q <= `CFC_RST_16;
			rxsh_q <= `CFC_RST_16;
			sdo_q <= 1'b0;
			oen_q <= 1'b1;
			fs_q <= 1'b0;
			wcnt_q <= '0;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			slot_q <= slot_d;
			lcfg_q <= lcfg_d;
			txsh_q <= txsh_d;
			rxsh_q <= rxsh_d;
			sdo_q <= sdo_d;
			oen_q <= oen_d;
			fs_q <= fs_d;
			wcnt_q <= wcnt_d;
		end
	end

	assign o_fsync = fs_q;
	assign o_serial_data_out = sdo_q;
	assign o_serial_data_out_oe_n = oen_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_word_end;
		fall && st_q == CFC_ST_RUN && ctl_q[`CFC_CTL_EN] && bit_q == lcfg_q.word_size;
	endsequence
	sequence s_frame_end;
		s_word_end ##0 (slot_q == lcfg_q.frm);
	endsequence
	sequence s_rx_skip;
		rise && st_q == CFC_ST_RUN && !lcfg_q.rx_en[slot_q];
	endsequence

	a_buf_irq_set: assert property (
		push.en && wcnt_q >= lcfg_q.buf_len |=> sts_q[`CFC_STS_BUF] && wcnt_q == 2'h0)
		else $error("buffer event not raised at set length");
	a_buf_irq_cause: assert property (
		$rose(sts_q[`CFC_STS_BUF]) |-> $past(push.en) && $past(wcnt_q >= lcfg_q.buf_len))
		else $error("buffer event without full buffer");
	a_frame_wrap: assert property (
		s_frame_end |=> slot_q == 4'h0 && bit_q == 4'h0 && o_fsync)
		else $error("frame did not wrap at set length");
	a_word_wrap: assert property (
		s_word_end |=> bit_q == 4'h0)
		else $error("word did not end at set size");
	a_rx_gate: assert property (
		push.en |-> lcfg_q.rx_en[slot_q] && $past(st_q) == CFC_ST_RUN)
		else $error("word captured in disabled slot");
	a_tx_drive: assert property (
		st_q == CFC_ST_RUN && $stable(st_q) && lcfg_q.tx_en[slot_q] |-> !o_serial_data_out_oe_n)
		else $error("enabled slot not driven");
	a_idle_pin: assert property (
		st_q == CFC_ST_RUN && !lcfg_q.tx_en[slot_q] |->
			!o_serial_data_out && (o_serial_data_out_oe_n == !lcfg_q.idle_low))
		else $error("disabled slot pin state wrong");
	a_slot_step: assert property (
		s_word_end ##0 (slot_q != lcfg_q.frm) |=> slot_q == $past(slot_q) + 4'h1)
		else $error("slot index did not advance by one");
	a_sync_slot0: assert property (
		o_fsync |-> slot_q == 4'h0 && bit_q == 4'h0)
		else $error("frame sync outside slot zero");
	a_rx_ignore: assert property (
		s_rx_skip |-> !push.en ##1 (rxsh_q == $past(rxsh_q)))
		else $error("input taken in disabled slot");
	a_buf_fill: assert property (
		push.en && wcnt_q < lcfg_q.buf_len |=> wcnt_q == $past(wcnt_q) + 2'h1)
		else $error("buffer index did not advance");
	a_sts_sticky: assert property (
		sts_q[`CFC_STS_BUF] && !(rd && i_paddr == `CFC_OFS_STATUS) |=> sts_q[`CFC_STS_BUF])
		else $error("buffer event lost without a status read");
	a_word_range: assert property (
		st_q == CFC_ST_RUN |-> bit_q <= lcfg_q.word_size)
		else $error("bit index past word size");
	a_slot_range: assert property (
		st_q == CFC_ST_RUN |-> slot_q <= lcfg_q.frm)
		else $error("slot index past frame length");
	a_link_idle: assert property (
		st_q == CFC_ST_IDLE |-> o_serial_data_out_oe_n && !o_fsync)
		else $error("link active while disabled");
endmodule

//--- common/cfc_map.svh
`ifndef CFC_MAP_SVH
`define CFC_MAP_SVH
// Overview of operation
// - Buffer interrupt after buffer_length_sel plus one words
// - Frame holds frame_length_sel plus one words
// - Word holds word_size_sel plus one bits
// - Receive only in slots with rx_slot_enable set
// - Transmit only in slots with tx_slot_enable set
// - Disabled transmit slot: tri-state or drive low

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CFC_ADDR_W 8
`define CFC_OFS_FRAMING 8'h00
`define CFC_OFS_RX_SLOTS 8'h04
`define CFC_OFS_TX_SLOTS 8'h08
`define CFC_OFS_CONTROL 8'h0C
`define CFC_OFS_TX_DATA 8'h10
`define CFC_OFS_STATUS 8'h14
`define CFC_OFS_MASK 8'h18
`define CFC_OFS_RX_BUF 8'h20
`define CFC_RX_BUF_SEL 8'hF0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CFC_BUF_LEN_MSB 11
`define CFC_BUF_LEN_LSB 10
`define CFC_FRM_MSB 8
`define CFC_FRM_LSB 5
`define CFC_WORD_SIZE_MSB 3
`define CFC_WORD_SIZE_LSB 0
`define CFC_FRAMING_MASK 16'h0DEF
`define CFC_CTL_EN 0
`define CFC_CTL_IDLE_LOW 1
`define CFC_STS_BUF 0
`define CFC_STS_FRAME 1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CFC_RST_16 16'h0000
`define CFC_RST_CTL 2'h0
`define CFC_RST_STS 2'h0
`define CFC_HALF_BIT 2
`define CFC_TOP_BIT 4'hF
`endif

//--- common/cfc_pkg.sv
package cfc_pkg;
	typedef enum logic [1:0] {
		CFC_ST_IDLE = 2'b01,
		CFC_ST_RUN = 2'b10
	} cfc_state_t;

	typedef struct packed {
		logic [1:0] buf_len;
		logic [3:0] frm;
		logic [3:0] word_size;
		logic [15:0] rx_en;
		logic [15:0] tx_en;
		logic idle_low;
	} cfc_link_cfg_t;

	typedef struct packed {
		logic en;
		logic [1:0] addr;
		logic [15:0] data;
	} cfc_wr_t;
endpackage

//--- rtl/cfc_bitclk.sv
`timescale 1ns/1ps
`include "cfc_map.svh"
module cfc_bitclk import cfc_pkg::*; #(
	parameter int HALF = `CFC_HALF_BIT
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	output logic o_sck,
	output logic o_rise,
	output logic o_fall
);
	localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);
	logic [CW-1:0] cnt_q, cnt_d;
	logic sck_q, sck_d;
	logic tog;

	always_comb begin
		tog = (cnt_q == LAST);
		cnt_d = tog ? '0 : cnt_q + 1'b1;
		sck_d = tog ? ~sck_q : sck_q;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= '0;
			sck_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			sck_q <= sck_d;
		end
	end

	assign o_sck = sck_q;
	assign o_rise = tog & ~sck_q;
	assign o_fall = tog & sck_q;
endmodule

//--- rtl/cfc_mem.sv
`timescale 1ns/1ps
module cfc_mem import cfc_pkg::*; #(
	parameter int W = 16,
	parameter int D = 4
) (
	input wire logic i_clk,
	input wire cfc_wr_t i_wr,
	input wire logic [$clog2(D)-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	logic [W-1:0] mem [D];
	logic [W-1:0] rd_q;

	// Storage has no reset; words are valid once written
	always_ff @(posedge i_clk) begin
		if (i_wr.en) begin
			mem[i_wr.addr] <= i_wr.data[W-1:0];
		end
		rd_q <= mem[i_raddr];
	end

	assign o_rdata = rd_q;
endmodule

//--- tb/cfc_codec_model.sv
`timescale 1ns/1ps
// Codec stand-in: plays a fixed frame pattern, records what it hears
module cfc_codec_model #(
	parameter logic [7:0] PAT = 8'hC5
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_sck,
	input wire logic i_fsync,
	input wire logic i_sdo,
	input wire logic i_oe_n,
	output logic o_sdi,
	output logic [7:0] o_data,
	output logic [7:0] o_float
);
	logic sck_q;
	logic [2:0] cnt_q;
	logic [7:0] dat_q;
	logic [7:0] flt_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sck_q <= 1'b0;
			cnt_q <= 3'h0;
			dat_q <= 8'h00;
			flt_q <= 8'h00;
			o_sdi <= 1'b0;
			o_data <= 8'h00;
			o_float <= 8'h00;
		end else begin
			sck_q <= i_sck;
			// New bit after each falling bit clock, restart at sync
			if (!i_sck && sck_q) begin
				o_sdi <= i_fsync ? PAT[7] : PAT[3'd7 - cnt_q];
				cnt_q <= i_fsync ? 3'd1 : cnt_q + 3'd1;
			end
			// Sample on rising bit clock; a floating pin reads as 0
			if (i_sck && !sck_q) begin
				dat_q <= {dat_q[6:0], i_sdo & !i_oe_n};
				flt_q <= {flt_q[6:0], i_oe_n};
				if (i_fsync) begin
					o_data <= dat_q;
					o_float <= flt_q;
				end
			end
		end
	end
endmodule

//--- tb/cfc_top_bench.sv
`timescale 1ns/1ps
`include "cfc_map.svh"
module cfc_top_bench;
	localparam int HB = 2;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] w;
		logic [31:0] r;
		logic e;
	} cfc_row_t;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic sck, fsync, sdo, oe_n, sdi, irq, er;
	logic [7:0] paddr, heard, floated;
	logic [31:0] pwdata, prdata, rd;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int c;
	cfc_row_t rows [7] = '{
		'{`CFC_OFS_FRAMING, 32'hFFFF_FFFF, 32'h0000_0DEF, 1'b0},
		'{`CFC_OFS_RX_SLOTS, 32'h0000_A5C3, 32'h0000_A5C3, 1'b0},
		'{`CFC_OFS_TX_SLOTS, 32'hFFFF_5A3C, 32'h0000_5A3C, 1'b0},
		'{`CFC_OFS_CONTROL, 32'h0000_FFFE, 32'h0000_0002, 1'b0},
		'{`CFC_OFS_MASK, 32'h0000_FFFF, 32'h0000_0003, 1'b0},
		'{`CFC_OFS_STATUS, 32'h0000_FFFF, 32'h0000_0000, 1'b0},
		'{8'h1C, 32'h0000_1234, 32'h0000_0000, 1'b1}};
	logic [15:0] frm_rows [4] = '{16'h0023, 16'h000F, 16'h01E3, 16'h0047};

	cfc_top #(.HALF_BIT(HB)) i_cfc_top (.i_clk(clk), .i_nrst(nrst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_sck(sck),
		.o_fsync(fsync), .o_serial_data_out(sdo), .o_serial_data_out_oe_n(oe_n),
		.i_serial_data_in(sdi), .o_irq(irq));
	cfc_codec_model i_cfc_codec_model (.i_clk(clk), .i_nrst(nrst), .i_sck(sck),
		.i_fsync(fsync), .i_sdo(sdo), .i_oe_n(oe_n), .o_sdi(sdi), .o_data(heard),
		.o_float(floated));

	// ----------------------------------------------------------------
	// Bus, compare and closing tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Counts cycles until the next rising frame sync; period is the count plus one
	task automatic wait_fs();
		logic p;
		c = 0;
		p = fsync;
		@(posedge clk);
		while (!(fsync === 1'b1 && p === 1'b0)) begin
			p = fsync;
			c++;
			@(posedge clk);
		end
	endtask
	task automatic conclude();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		{nrst, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk("oe_n at reset", 1'b1, oe_n);
		chk("irq at reset", 1'b0, irq);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", 32'h0, rd);
		end
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 32'h0);
			chk("readback", rows[i].r, rd);
			chk("slverr", rows[i].e, er);
		end
		$display("test registers done");
		// Two 4-bit slots, two buffered words, receive slot 0, send slot 1
		apb(1'b1, `CFC_OFS_FRAMING, 32'h0000_0423);
		apb(1'b1, `CFC_OFS_RX_SLOTS, 32'h0000_0001);
		apb(1'b1, `CFC_OFS_TX_SLOTS, 32'h0000_0002);
		apb(1'b1, `CFC_OFS_TX_DATA, 32'h0000_000A);
		apb(1'b1, `CFC_OFS_MASK, 32'h0000_0001);
		apb(1'b1, `CFC_OFS_CONTROL, 32'h0000_0003);
		repeat (3) wait_fs();
		chk("tx frame", 8'h0A, heard);
		chk("tx float", 8'h00, floated);
		chk("irq raised", 1'b1, irq);
		apb(1'b0, `CFC_OFS_STATUS, 32'h0);
		chk("buffer event", 1'b1, rd[`CFC_STS_BUF]);
		chk("irq cleared", 1'b0, irq);
		for (int i = 0; i < 2; i++) begin
			apb(1'b0, 8'(`CFC_OFS_RX_BUF + i * 4), 32'h0);
			chk("rx word", 4'hC, rd[3:0]);
		end
		$display("test slots done");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `CFC_OFS_FRAMING, {16'h0, frm_rows[i]});
			repeat (2) wait_fs();
			wait_fs();
			chk("frame period", (32'(frm_rows[i][3:0]) + 1) * (32'(frm_rows[i][8:5]) + 1) * 2 * HB,
				c + 1);
		end
		$display("test framing done");
		apb(1'b1, `CFC_OFS_FRAMING, 32'h0000_0023);
		apb(1'b1, `CFC_OFS_CONTROL, 32'h0000_0001);
		repeat (3) wait_fs();
		chk("tri-state slot", 8'hF0, floated);
		chk("tx frame", 8'h0A, heard);
		$display("test idle mode done");
		conclude();
	end
endmodule
